// >>> rtl/deflection_reset_protect_pkg.sv
// Package for the deflection reset and protection block.
// Assumes a 10 MHz system clock and a 32-bit AXI4-Lite register port.
package deflection_reset_protect_pkg;

    // Clock rate
    localparam int unsigned CLK_HZ = 10_000_000;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_PHASE_TARGET = 8'h08;
    localparam logic [7:0] OFS_DELAY_COMP = 8'h0C;
    localparam logic [7:0] OFS_AUX = 8'h10;
    localparam logic [7:0] OFS_RASTER_INDEX = 8'h14;
    localparam logic [7:0] OFS_RASTER_DATA = 8'h18;
    localparam logic [7:0] OFS_PHASE = 8'h1C;

    // Control word fields
    localparam int CTRL_FIELD_120_BIT = 0;
    localparam int CTRL_RASTER_RAM_BIT = 1;
    localparam int CTRL_SOFT_BLANK_BIT = 2;

    // Status word fields
    localparam int STAT_FIELD_120_BIT = 0;
    localparam int STAT_STANDBY_BIT = 1;
    localparam int STAT_RASTER_RAM_BIT = 2;
    localparam int STAT_DRIVE_FORCED_BIT = 6;
    localparam int STAT_RESET_SOURCE_BIT = 7;

    // Values after reset
    localparam logic [11:0] PHASE_TARGET_RESET = 12'h020;
    localparam logic [11:0] PHASE_RESET = 12'h010;
    localparam logic [7:0] DELAY_COMP_RESET = 8'h04;
    localparam logic [7:0] AUX_RESET = 8'h00;

    // Timing figures and derived cycle counts
    localparam int unsigned STARTUP_DELAY_US = 100;
    localparam int unsigned STARTUP_CYCLES = STARTUP_DELAY_US * (CLK_HZ / 1_000_000);
    localparam int unsigned BURST_START_NS = 500;
    localparam int unsigned BURST_START_CYCLES =
        (BURST_START_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned BURST_LEN_NS = 1000;
    localparam int unsigned BURST_LEN_CYCLES = BURST_LEN_NS * (CLK_HZ / 1_000_000) / 1000;
    localparam int unsigned VBLANK_LINES = 20;

    // Key pulse levels
    localparam logic [1:0] KEY_LOW = 2'h0;
    localparam logic [1:0] KEY_BURST = 2'h1;
    localparam logic [1:0] KEY_BLANK = 2'h2;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Fixed raster table
    localparam int RASTER_DEPTH = 8;
    localparam logic [15:0] RASTER_ROM [0:RASTER_DEPTH-1] = '{
        16'h0000, 16'h0960, 16'h0A28, 16'h05AA,
        16'h0000, 16'h0190, 16'h0000, 16'h0000
    };

    // Start-up logic states
    typedef enum logic [1:0] {
        ST_STANDBY = 2'b01,
        ST_RUN = 2'b10
    } startup_state_t;

endpackage

// >>> rtl/deflection_reset_protect.sv
// Reset, protection, horizontal drive and key pulse logic of a deflection controller.
// Assumes pins are asynchronous to aclk and that aresetn is the power-on reset.
//
// Behaviour
// - Upper-threshold sense: key pulse to blanking level and drive forced high.
// - Lower-threshold sense: blanking only, drive keeps running normally.
// - Drive gate input low suppresses drive pulses.
// - Drive rising edge starts retrace; constant duty, transfer delay compensated.
// - Drive stays high while line retrace feedback is active.
// - Drive phase adjusted so retrace lands at a fixed line position.
// - Two-level key pulse built from line flyback, frame flyback and burst.
// - Protection can switch key pulse to continuous blanking.
// - Both resets initialise start-up and phase loop; the line divider is reset by power-on reset only.
// - Reset selects 100 Hz field mode and fixed table raster data.
// - Fixed table data used until software selects writable memory.
// - Key pulse blanks during reset.
// - Start-up logic enters standby on supply rise or external reset.
// - Drive pulses continue during external reset.
// - External reset keeps raster memory and auxiliary port contents.
// - External reset leaves the register port alone.
// - Every reset sets the reset source flag.
// - External reset leaves reference outputs unchanged.
// - Reset source flag reads 1 after power-on or external reset, 0 after a status read.
// - Raster source bit 0 selects fixed table, 1 selects writable memory.
// - Forced drive status bit is 1 while protection holds drive high.
`timescale 1ns/1ps

module deflection_reset_protect #(
    parameter int CNT_W = 12,
    parameter int STARTUP_COUNT = deflection_reset_protect_pkg::STARTUP_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins
    input wire logic ext_reset_n_in,
    input wire logic startup_supply_in,
    input wire logic sense_high_in,
    input wire logic sense_low_in,
    input wire logic hdrive_gate_in,
    input wire logic line_retrace_in,
    input wire logic line_sync_in,
    input wire logic frame_sync_in,
    output logic hdrive_out,
    output logic [1:0] key_pulse_out,
    output logic standby_out,
    output logic [7:0] aux_output_port,
    output logic [15:0] raster_word_out
);

    localparam int NPIN = 8;
    localparam int P_EXT = 0;
    localparam int P_SUP = 1;
    localparam int P_SHI = 2;
    localparam int P_SLO = 3;
    localparam int P_GATE = 4;
    localparam int P_RET = 5;
    localparam int P_LS = 6;
    localparam int P_FS = 7;

    logic [NPIN-1:0] pin_meta_q;
    logic [NPIN-1:0] pin_sync_q;
    logic [NPIN-1:0] pin_prev_q;
    logic ext_rst;
    logic dev_rst;
    logic supply_rise;
    logic retrace_rise;
    logic retrace_fall;
    logic line_rise;
    logic frame_rise;

    logic field_120_q;
    logic raster_ram_q;
    logic soft_blank_q;
    logic [11:0] phase_target_q;
    logic [7:0] delay_comp_q;
    logic [2:0] raster_index_q;
    logic [15:0] raster_mem [0:deflection_reset_protect_pkg::RASTER_DEPTH-1];
    logic reset_source_q;
    logic drive_forced_q;

    logic [7:0] aw_addr_q;
    logic aw_have_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic w_have_q;
    logic wr_fire;
    logic rd_fire;
    logic stat_read;
    logic [31:0] rd_word;
    logic rd_hit;
    logic [15:0] raster_sel;

    deflection_reset_protect_pkg::startup_state_t state_q;
    logic [15:0] startup_cnt_q;

    logic [CNT_W-1:0] line_cnt_q;
    logic [CNT_W-1:0] period_q;
    logic [11:0] phase_q;
    logic [CNT_W-1:0] drive_start;
    logic [CNT_W-1:0] drive_end;
    logic drive_window;
    logic [7:0] vblank_cnt_q;
    logic [7:0] burst_cnt_q;
    logic burst_win;
    logic cont_blank;

    // Two-flop synchronisers; the second stage and its one-cycle delayed copy for edge detection feed logic
    always_ff @(posedge aclk) begin
        pin_meta_q <= {frame_sync_in, line_sync_in, line_retrace_in, hdrive_gate_in,
                       sense_low_in, sense_high_in, startup_supply_in, ~ext_reset_n_in};
        pin_sync_q <= pin_meta_q;
        pin_prev_q <= pin_sync_q;
    end

    // Edge detection on synchronised pins
    assign ext_rst = pin_sync_q[P_EXT];
    assign dev_rst = ~aresetn | ext_rst;
    assign supply_rise = pin_sync_q[P_SUP] & ~pin_prev_q[P_SUP];
    assign retrace_rise = pin_sync_q[P_RET] & ~pin_prev_q[P_RET];
    assign retrace_fall = ~pin_sync_q[P_RET] & pin_prev_q[P_RET];
    assign line_rise = pin_sync_q[P_LS] & ~pin_prev_q[P_LS];
    assign frame_rise = pin_sync_q[P_FS] & ~pin_prev_q[P_FS];

    // AXI write channels, taken in either order; port ignores external reset
    assign s_axi_awready = ~aw_have_q;
    assign s_axi_wready = ~w_have_q;
    assign wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_have_q <= 1'b0;
        end
    end

    // Write response; unmapped or read-only offsets answer SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= deflection_reset_protect_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            case (aw_addr_q)
                deflection_reset_protect_pkg::OFS_CTRL,
                deflection_reset_protect_pkg::OFS_PHASE_TARGET,
                deflection_reset_protect_pkg::OFS_DELAY_COMP,
                deflection_reset_protect_pkg::OFS_AUX,
                deflection_reset_protect_pkg::OFS_RASTER_INDEX,
                deflection_reset_protect_pkg::OFS_RASTER_DATA:
                    s_axi_bresp <= deflection_reset_protect_pkg::RESP_OKAY;
                default: s_axi_bresp <= deflection_reset_protect_pkg::RESP_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Control word; both resets return to 100 Hz and fixed table data
    always_ff @(posedge aclk) begin
        if (dev_rst) begin
            field_120_q <= 1'b0;
            raster_ram_q <= 1'b0;
            soft_blank_q <= 1'b0;
        end else if (wr_fire && aw_addr_q == deflection_reset_protect_pkg::OFS_CTRL
                     && w_strb_q[0]) begin
            field_120_q <= w_data_q[deflection_reset_protect_pkg::CTRL_FIELD_120_BIT];
            raster_ram_q <= w_data_q[deflection_reset_protect_pkg::CTRL_RASTER_RAM_BIT];
            soft_blank_q <= w_data_q[deflection_reset_protect_pkg::CTRL_SOFT_BLANK_BIT];
        end
    end

    // Alignment settings survive external reset, like aux port, raster index and raster memory; the control word does not
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_target_q <= deflection_reset_protect_pkg::PHASE_TARGET_RESET;
            delay_comp_q <= deflection_reset_protect_pkg::DELAY_COMP_RESET;
            aux_output_port <= deflection_reset_protect_pkg::AUX_RESET;
            raster_index_q <= 3'h0;
        end else if (wr_fire) begin
            if (aw_addr_q == deflection_reset_protect_pkg::OFS_PHASE_TARGET) begin
                if (w_strb_q[0]) phase_target_q[7:0] <= w_data_q[7:0];
                if (w_strb_q[1]) phase_target_q[11:8] <= w_data_q[11:8];
            end
            if (aw_addr_q == deflection_reset_protect_pkg::OFS_DELAY_COMP && w_strb_q[0]) begin
                delay_comp_q <= w_data_q[7:0];
            end
            if (aw_addr_q == deflection_reset_protect_pkg::OFS_AUX && w_strb_q[0]) begin
                aux_output_port <= w_data_q[7:0];
            end
            if (aw_addr_q == deflection_reset_protect_pkg::OFS_RASTER_INDEX && w_strb_q[0]) begin
                raster_index_q <= w_data_q[2:0];
            end
        end
    end

    // Raster memory has no reset at all, so contents survive any reset
    always_ff @(posedge aclk) begin
        if (wr_fire && aw_addr_q == deflection_reset_protect_pkg::OFS_RASTER_DATA) begin
            if (w_strb_q[0]) raster_mem[raster_index_q][7:0] <= w_data_q[7:0];
            if (w_strb_q[1]) raster_mem[raster_index_q][15:8] <= w_data_q[15:8];
        end
    end

    // Raster source selection
    assign raster_sel = raster_ram_q ? raster_mem[raster_index_q]
                                     : deflection_reset_protect_pkg::RASTER_ROM[raster_index_q];

    always_ff @(posedge aclk) begin
        raster_word_out <= raster_sel;
    end

    // Read channel; one-cycle latency after address is taken
    assign s_axi_arready = ~s_axi_rvalid;
    assign rd_fire = s_axi_arvalid & s_axi_arready;
    assign stat_read = rd_fire & (s_axi_araddr == deflection_reset_protect_pkg::OFS_STATUS);

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            deflection_reset_protect_pkg::OFS_CTRL: begin
                rd_word[deflection_reset_protect_pkg::CTRL_FIELD_120_BIT] = field_120_q;
                rd_word[deflection_reset_protect_pkg::CTRL_RASTER_RAM_BIT] = raster_ram_q;
                rd_word[deflection_reset_protect_pkg::CTRL_SOFT_BLANK_BIT] = soft_blank_q;
            end
            deflection_reset_protect_pkg::OFS_STATUS: begin
                rd_word[deflection_reset_protect_pkg::STAT_FIELD_120_BIT] = field_120_q;
                rd_word[deflection_reset_protect_pkg::STAT_STANDBY_BIT] = standby_out;
                rd_word[deflection_reset_protect_pkg::STAT_RASTER_RAM_BIT] = raster_ram_q;
                rd_word[deflection_reset_protect_pkg::STAT_DRIVE_FORCED_BIT] =
                    drive_forced_q;
                rd_word[deflection_reset_protect_pkg::STAT_RESET_SOURCE_BIT] =
                    reset_source_q;
            end
            deflection_reset_protect_pkg::OFS_PHASE_TARGET: rd_word[11:0] = phase_target_q;
            deflection_reset_protect_pkg::OFS_DELAY_COMP: rd_word[7:0] = delay_comp_q;
            deflection_reset_protect_pkg::OFS_AUX: rd_word[7:0] = aux_output_port;
            deflection_reset_protect_pkg::OFS_RASTER_INDEX: rd_word[2:0] = raster_index_q;
            deflection_reset_protect_pkg::OFS_RASTER_DATA: rd_word[15:0] = raster_sel;
            deflection_reset_protect_pkg::OFS_PHASE: rd_word[11:0] = phase_q;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= deflection_reset_protect_pkg::RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? deflection_reset_protect_pkg::RESP_OKAY
                                  : deflection_reset_protect_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Reset source flag: set by any device reset, cleared by a status read.
    // Set wins so a reset coinciding with the read is not lost.
    always_ff @(posedge aclk) begin
        if (dev_rst) begin
            reset_source_q <= 1'b1;
        end else if (stat_read) begin
            reset_source_q <= 1'b0;
        end
    end

    // Upper-threshold trip latches until power-on reset; external reset keeps it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drive_forced_q <= 1'b0;
        end else if (pin_sync_q[P_SHI]) begin
            drive_forced_q <= 1'b1;
        end
    end

    // Start-up logic: standby on supply rise or external reset, run after delay
    always_ff @(posedge aclk) begin
        if (dev_rst || supply_rise) begin
            state_q <= deflection_reset_protect_pkg::ST_STANDBY;
            startup_cnt_q <= 16'h0000;
        end else begin
            case (state_q)
                deflection_reset_protect_pkg::ST_STANDBY: begin
                    if (startup_cnt_q == 16'(STARTUP_COUNT - 1)) begin
                        state_q <= deflection_reset_protect_pkg::ST_RUN;
                    end else begin
                        startup_cnt_q <= startup_cnt_q + 16'h0001;
                    end
                end
                deflection_reset_protect_pkg::ST_RUN: state_q <= state_q;
                default: state_q <= deflection_reset_protect_pkg::ST_STANDBY;
            endcase
        end
    end

    assign standby_out = (state_q != deflection_reset_protect_pkg::ST_RUN);

    // Line timing runs on the sync reference; not reset by external reset
    // so drive pulses carry on through it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            line_cnt_q <= '0;
            period_q <= '0;
        end else if (line_rise) begin
            line_cnt_q <= '0;
            period_q <= line_cnt_q;
        end else if (line_cnt_q != {CNT_W{1'b1}}) begin
            line_cnt_q <= line_cnt_q + 1'b1;
        end
    end

    // Phase loop: steps the drive phase one count per line toward the target
    always_ff @(posedge aclk) begin
        if (dev_rst) begin
            phase_q <= deflection_reset_protect_pkg::PHASE_RESET;
        end else if (retrace_rise) begin
            if (CNT_W'(phase_target_q) < line_cnt_q && phase_q != 12'h000) begin
                phase_q <= phase_q - 12'h001;
            end else if (CNT_W'(phase_target_q) > line_cnt_q && phase_q != 12'hFFF) begin
                phase_q <= phase_q + 12'h001;
            end
        end
    end

    // Drive window: start advanced by the transfer delay, width half the period
    assign drive_start = (CNT_W'(phase_q) > CNT_W'(delay_comp_q))
                         ? CNT_W'(phase_q) - CNT_W'(delay_comp_q) : '0;
    assign drive_end = drive_start + (period_q >> 1);
    assign drive_window = (line_cnt_q >= drive_start) && (line_cnt_q < drive_end)
                          && (period_q != '0);

    // Drive output: forced high by protection, high during retrace, else gated pulses
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hdrive_out <= 1'b0;
        end else if (drive_forced_q || pin_sync_q[P_SHI]) begin
            hdrive_out <= 1'b1;
        end else if (pin_sync_q[P_RET]) begin
            hdrive_out <= 1'b1;
        end else begin
            hdrive_out <= pin_sync_q[P_GATE] & drive_window;
        end
    end

    // Frame flyback: blank a fixed count of lines after frame sync
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vblank_cnt_q <= 8'h00;
        end else if (frame_rise) begin
            vblank_cnt_q <= 8'(deflection_reset_protect_pkg::VBLANK_LINES);
        end else if (line_rise && vblank_cnt_q != 8'h00) begin
            vblank_cnt_q <= vblank_cnt_q - 8'h01;
        end
    end

    // Burst gate timed from the end of line retrace
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            burst_cnt_q <= 8'hFF;
        end else if (retrace_fall) begin
            burst_cnt_q <= 8'h00;
        end else if (burst_cnt_q != 8'hFF) begin
            burst_cnt_q <= burst_cnt_q + 8'h01;
        end
    end

    assign burst_win = (burst_cnt_q >= 8'(deflection_reset_protect_pkg::BURST_START_CYCLES))
        && (burst_cnt_q < 8'(deflection_reset_protect_pkg::BURST_START_CYCLES
                            + deflection_reset_protect_pkg::BURST_LEN_CYCLES))
        && (vblank_cnt_q == 8'h00);

    // Continuous blanking from protection, reset, start-up or software
    assign cont_blank = pin_sync_q[P_SHI] | pin_sync_q[P_SLO] | drive_forced_q
                        | dev_rst | standby_out | soft_blank_q;

    // Two-level key pulse; blanking outranks burst
    always_ff @(posedge aclk) begin
        if (cont_blank) begin
            key_pulse_out <= deflection_reset_protect_pkg::KEY_BLANK;
        end else if (pin_sync_q[P_RET] || vblank_cnt_q != 8'h00) begin
            key_pulse_out <= deflection_reset_protect_pkg::KEY_BLANK;
        end else if (burst_win) begin
            key_pulse_out <= deflection_reset_protect_pkg::KEY_BURST;
        end else begin
            key_pulse_out <= deflection_reset_protect_pkg::KEY_LOW;
        end
    end

    // Reference outputs (aux port) have no external reset path

endmodule // deflection_reset_protect

// >>> tb/deflection_reset_protect_props.sv
// Checker for the deflection reset and protection block.
// Bound to every instance of the block and sees only its ports.
`timescale 1ns/1ps
module deflection_reset_protect_props #(
    parameter int CNT_W = 12,
    parameter int STARTUP_COUNT = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ext_reset_n_in,
    input wire logic sense_high_in,
    input wire logic sense_low_in,
    input wire logic hdrive_gate_in,
    input wire logic line_retrace_in,
    input wire logic s_axi_bvalid,
    input wire logic hdrive_out,
    input wire logic [1:0] key_pulse_out,
    input wire logic standby_out,
    input wire logic [7:0] aux_output_port
);
    localparam logic [1:0] BLK = deflection_reset_protect_pkg::KEY_BLANK;
    // Pins pass two synchroniser stages and one output register
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_force_drive: assert property (sense_high_in [*3] |=> hdrive_out)
        else $error("drive not forced high");
    a_force_key: assert property (sense_high_in [*3] |=> key_pulse_out == BLK)
        else $error("no blanking on upper trip");
    a_low_blank: assert property (sense_low_in [*3] |=> key_pulse_out == BLK)
        else $error("no blanking on lower trip");
    a_gate_rise: assert property ($rose(hdrive_out) |-> $past(hdrive_gate_in, 3)
        || $past(line_retrace_in, 3) || $past(sense_high_in, 3)) else $error("ungated drive");
    a_retrace_high: assert property (line_retrace_in [*3] |=> hdrive_out)
        else $error("drive low during retrace");
    a_ext_blank: assert property (!ext_reset_n_in [*3] |=> key_pulse_out == BLK)
        else $error("no blanking in reset");
    a_ext_standby: assert property (!ext_reset_n_in [*3] |=> standby_out)
        else $error("no standby in reset");
    // Aux port only moves with a write response, never on a reset pin
    a_aux_writes: assert property ($changed(aux_output_port) |-> s_axi_bvalid)
        else $error("aux port changed without write");
endmodule // deflection_reset_protect_props

bind deflection_reset_protect deflection_reset_protect_props #(
    .CNT_W(CNT_W), .STARTUP_COUNT(STARTUP_COUNT)) props_u (.*);

// >>> tb/deflection_stage_model.sv
// Model of the horizontal output stage and the sync source.
// Retrace follows each rising drive edge; syncs run from a free counter.
`timescale 1ns/1ps
module deflection_stage_model (
    input wire logic aclk,
    input wire logic hdrive_out,
    output logic line_sync_in = 1'h0,
    output logic frame_sync_in = 1'h0,
    output logic line_retrace_in = 1'h0
);
    logic [11:0] cnt_q = 12'h000;
    logic [3:0] ret_q = 4'h0;
    logic hd_q = 1'h0;
    // 64-cycle lines, 64 lines a frame; flyback 5 cycles after drive rise, 8 long
    always @(posedge aclk) begin
        cnt_q <= cnt_q + 12'h001;
        line_sync_in <= cnt_q[5:0] < 6'h04;
        frame_sync_in <= cnt_q[11:2] == 10'h000;
        hd_q <= hdrive_out;
        if (hdrive_out && !hd_q) ret_q <= 4'hB;
        else if (ret_q != 4'h0) ret_q <= ret_q - 4'h1;
        line_retrace_in <= ret_q != 4'h0 && ret_q < 4'h9;
    end
endmodule // deflection_stage_model

// >>> tb/test_deflection_reset_protect.sv
// Testbench for the deflection reset and protection block.
// Acts as AXI4-Lite master; the stage model closes the drive loop.
`timescale 1ns/1ps
module test_deflection_reset_protect;
    logic aclk = 1'h0, aresetn = 1'h0, ext_reset_n_in = 1'h1, startup_supply_in = 1'h1;
    logic sense_high_in = 1'h0, sense_low_in = 1'h0, hdrive_gate_in = 1'h1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
    logic s_axi_bready = 1'h1, s_axi_rready = 1'h1, hd_last;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, key_pulse_out, r;
    logic line_retrace_in, line_sync_in, frame_sync_in, hdrive_out, standby_out;
    logic [7:0] aux_output_port;
    logic [15:0] raster_word_out;
    int err_total = 0, cmp_count = 0, rises = 0, bursts = 0, r0;
    deflection_reset_protect #(.STARTUP_COUNT(8)) dut_u (.*);
    deflection_stage_model stage_u (.*);
    always #50 aclk = ~aclk;
    // Counts drive rising edges and cycles at burst level
    always @(posedge aclk) begin
        if (hdrive_out === 1'h1 && hd_last === 1'h0) rises++;
        if (key_pulse_out === 2'h1) bursts++;
        hd_last <= hdrive_out;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Ready is sampled at the falling edge, where it is settled
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic ka, kw, kb;
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(negedge aclk);
            ka = s_axi_awready;
            kw = s_axi_wready;
            kb = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (ka) s_axi_awvalid <= 1'h0;
            if (kw) s_axi_wvalid <= 1'h0;
            if (kb) break;
        end
        if (n == 50) begin
            err_total++;
            summarize();
        end
    endtask
    task automatic rd(input logic [7:0] a);
        logic ka, kb;
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(negedge aclk);
            ka = s_axi_arready;
            kb = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ka) s_axi_arvalid <= 1'h0;
            if (kb) break;
        end
        if (n == 50) begin
            err_total++;
            summarize();
        end
    endtask
    task automatic t_boot();
        rd(8'h04);
        chk(d & 32'hC5, 32'h80);
        rd(8'h04);
        chk(d & 32'h80, 32'h0);
        rd(8'h20);
        chk(r, 2'h2);
        wr(8'h04, 32'h0);
        chk(r, 2'h2);
        $display("boot done");
    endtask
    task automatic t_raster();
        wr(8'h14, 32'h1);
        wr(8'h18, 32'h1234);
        rd(8'h18);
        chk(d, deflection_reset_protect_pkg::RASTER_ROM[1]);
        wr(8'h00, 32'h2);
        rd(8'h18);
        chk(d, 32'h1234);
        chk(raster_word_out, 16'h1234);
        $display("raster done");
    endtask
    task automatic t_ext();
        wr(8'h10, 32'h5A);
        r0 = rises;
        ext_reset_n_in <= 1'h0;
        repeat (200) @(posedge aclk);
        chk(standby_out, 1'h1);
        chk(rises > r0, 1'h1);
        ext_reset_n_in <= 1'h1;
        repeat (4) @(posedge aclk);
        chk(aux_output_port, 8'h5A);
        rd(8'h04);
        chk(d & 32'h85, 32'h80);
        rd(8'h18);
        chk(d, deflection_reset_protect_pkg::RASTER_ROM[1]);
        wr(8'h00, 32'h2);
        rd(8'h18);
        chk(d, 32'h1234);
        $display("ext reset done");
    endtask
    task automatic t_gate();
        hdrive_gate_in <= 1'h0;
        repeat (80) @(posedge aclk);
        r0 = rises;
        repeat (200) @(posedge aclk);
        chk(rises - r0, 0);
        hdrive_gate_in <= 1'h1;
        repeat (200) @(posedge aclk);
        chk(rises > r0, 1'h1);
        chk(bursts > 0, 1'h1);
        $display("gate done");
    endtask
    task automatic t_sense();
        sense_low_in <= 1'h1;
        r0 = rises;
        repeat (200) @(posedge aclk);
        chk(key_pulse_out, 2'h2);
        chk(rises > r0, 1'h1);
        sense_low_in <= 1'h0;
        sense_high_in <= 1'h1;
        repeat (5) @(posedge aclk);
        chk(hdrive_out, 1'h1);
        sense_high_in <= 1'h0;
        repeat (200) @(posedge aclk);
        chk(hdrive_out, 1'h1);
        rd(8'h04);
        chk(d & 32'h40, 32'h40);
        $display("sense done");
    endtask
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (12) @(posedge aclk);
        t_boot();
        t_raster();
        t_ext();
        t_gate();
        t_sense();
        summarize();
    end
endmodule // test_deflection_reset_protect
